// *** design/bio_params.svh ***
/*
 * Constants for the branch, I/O-bit and shift execution block: register
 * offsets, field positions, reset values and cycle counts.
 * Assumes it is included by bare name from bio_shift and bio_exec.
 */
// Function
// - Overflow clear: jump to pc plus offset plus one
// - Interrupts enabled: jump, flags untouched
// - Interrupts disabled: jump, else fall through
// - Set one I/O bit, two cycles
// - Clear one I/O bit, two cycles
// - Shift left, update Z C N V, one cycle
`ifndef BIO_PARAMS_SVH
`define BIO_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define BIO_OFS_CTRL    8'h00
`define BIO_OFS_PC      8'h04
`define BIO_OFS_FLAGS   8'h08

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BIO_CTRL_EN     0
`define BIO_CTRL_RST    1'h1
`define BIO_FLG_Z       0
`define BIO_FLG_C       1
`define BIO_FLG_N       2
`define BIO_FLG_V       3

// ****************************************************************
// Cycle counts
// ****************************************************************
`define BIO_CYC_BR_MISS 1
`define BIO_CYC_BR_HIT  2
`define BIO_CYC_IOBIT   2
`define BIO_CYC_SHIFT   1

`endif

// *** design/bio_pkg.sv ***
/*
 * Types shared by the execution block: instruction codes and states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package bio_pkg;

   typedef enum logic [2:0] {
      BIO_OP_NONE   = 3'h0,
      BIO_OP_BR_OVC = 3'h1,
      BIO_OP_BR_IEN = 3'h2,
      BIO_OP_BR_IDS = 3'h3,
      BIO_OP_IO_SET = 3'h4,
      BIO_OP_IO_CLR = 3'h5,
      BIO_OP_SHL    = 3'h6
   } bio_op_t;

   // Gray along idle -> flush and idle -> rmw
   typedef enum logic [1:0] {
      BIO_ST_IDLE  = 2'h0,
      BIO_ST_FLUSH = 2'h1,
      BIO_ST_RMW   = 2'h2
   } bio_state_t;

endpackage
`default_nettype wire

// *** design/bio_shift.sv ***
/*
 * Logical shift left of one working register with flag results.
 * Assumes the operand is stable in the cycle it is evaluated.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bio_params.svh"

module bio_shift (
   input  wire logic [7:0] rd_i,
   output logic      [7:0] res_o,
   output logic      [3:0] flags_o
);

   // The shifted-out bit becomes carry; overflow is N xor C
   assign res_o                 = {rd_i[6:0], 1'b0};
   assign flags_o[`BIO_FLG_C]   = rd_i[7];
   assign flags_o[`BIO_FLG_N]   = rd_i[6];
   assign flags_o[`BIO_FLG_Z]   = (rd_i[6:0] == 7'h00);
   assign flags_o[`BIO_FLG_V]   = rd_i[7] ^ rd_i[6];

endmodule
`default_nettype wire

// *** design/bio_exec.sv ***
/*
 * Executes three conditional relative branches, set/clear of one I/O
 * register bit and logical shift left; owns the program counter.
 * Assumes instructions arrive synchronous to clk_sys_i and that the I/O
 * space answers a read strobe with data in the following cycle.
 */
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "bio_params.svh"

module bio_exec #(
   parameter int PCW = 10
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             instr_valid_i,
   input  wire bio_pkg::bio_op_t instr_op_i,
   input  wire logic [6:0]       instr_k_i,
   input  wire logic [4:0]       instr_io_i,
   input  wire logic [2:0]       instr_bit_i,
   input  wire logic [7:0]       rd_val_i,
   input  wire logic             v_flag_i,
   input  wire logic             i_flag_i,
   output logic                  ready_o,
   output logic                  flush_o,
   output logic [PCW-1:0]        pc_o,
   output logic [4:0]            io_addr_o,
   output logic                  io_re_o,
   input  wire logic [7:0]       io_rdata_i,
   output logic                  io_we_o,
   output logic [7:0]            io_wdata_o,
   output logic                  rd_we_o,
   output logic [7:0]            rd_res_o,
   output logic                  flags_we_o,
   output logic [3:0]            flags_o,
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic [31:0]      reg_wdata_i,
   input  wire logic             reg_we_i,
   input  wire logic             reg_re_i,
   output logic [31:0]           reg_rdata_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   bio_pkg::bio_state_t state;
   bio_pkg::bio_state_t next_state;
   logic                en;
   logic [4:0]          io_addr_q;
   logic [2:0]          bit_q;
   logic                set_q;
   logic [PCW-1:0]      next_pc;
   logic [7:0]          shl_res;
   logic [3:0]          shl_flags;

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire logic acc       = instr_valid_i && ready_o;
   wire logic is_br_ovc = instr_op_i == bio_pkg::BIO_OP_BR_OVC;
   wire logic is_br_ien = instr_op_i == bio_pkg::BIO_OP_BR_IEN;
   wire logic is_br_ids = instr_op_i == bio_pkg::BIO_OP_BR_IDS;
   wire logic is_io     = instr_op_i == bio_pkg::BIO_OP_IO_SET ||
                          instr_op_i == bio_pkg::BIO_OP_IO_CLR;
   wire logic is_shl    = instr_op_i == bio_pkg::BIO_OP_SHL;
   wire logic taken     = (is_br_ovc && !v_flag_i)
                       || (is_br_ien && i_flag_i)
                       || (is_br_ids && !i_flag_i);
   wire logic [PCW-1:0] k_ext = PCW'({{(PCW-7){instr_k_i[6]}}, instr_k_i});
   wire logic [PCW-1:0] pc_seq = pc_o + PCW'(1);
   wire logic [PCW-1:0] pc_jmp = pc_o + k_ext + PCW'(1);

   wire logic sel_ctrl  = reg_addr_i == `BIO_OFS_CTRL;
   wire logic sel_pc    = reg_addr_i == `BIO_OFS_PC;
   wire logic sel_flags = reg_addr_i == `BIO_OFS_FLAGS;
   wire logic [31:0] rd_mux =
      sel_ctrl  ? 32'({en})    :
      sel_pc    ? 32'(pc_o)    :
      sel_flags ? 32'(flags_o) : 32'h0;

   // ****************************************************************
   // Sequencing
   // ****************************************************************
   // Not allowed to accept while flushing or finishing a bit update
   assign ready_o  = ce_i && en && state == bio_pkg::BIO_ST_IDLE;
   assign flush_o  = state == bio_pkg::BIO_ST_FLUSH;
   assign next_pc  = (acc && taken) ? pc_jmp : pc_seq;

   always_comb begin
      next_state = bio_pkg::BIO_ST_IDLE;
      unique case (state)
         bio_pkg::BIO_ST_IDLE: begin
            if (acc && taken)
               next_state = bio_pkg::BIO_ST_FLUSH;
            else if (acc && is_io)
               next_state = bio_pkg::BIO_ST_RMW;
         end
         bio_pkg::BIO_ST_FLUSH: next_state = bio_pkg::BIO_ST_IDLE;
         bio_pkg::BIO_ST_RMW:   next_state = bio_pkg::BIO_ST_IDLE;
         default:               next_state = bio_pkg::BIO_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i)
         state <= bio_pkg::BIO_ST_IDLE;
      else if (ce_i)
         state <= next_state;
   end

   // An instruction retiring in the same cycle wins over a bus write
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i)
         pc_o <= '0;
      else if (ce_i && acc)
         pc_o <= next_pc;
      else if (ce_i && reg_we_i && sel_pc)
         pc_o <= reg_wdata_i[PCW-1:0];
   end

   // ****************************************************************
   // I/O bit read-modify-write
   // ****************************************************************
   // Address is live in the accept cycle so the read returns next cycle
   assign io_addr_o = (state == bio_pkg::BIO_ST_RMW) ? io_addr_q
                                                     : instr_io_i;
   assign io_re_o   = acc && is_io;
   assign io_we_o   = ce_i && state == bio_pkg::BIO_ST_RMW;

   for (genvar g = 0; g < 8; g++) begin : g_bit
      assign io_wdata_o[g] = (bit_q == 3'(g)) ? set_q
                                              : io_rdata_i[g];
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         io_addr_q <= 5'h00;
         bit_q     <= 3'h0;
         set_q     <= 1'b0;
      end else if (ce_i && acc && is_io) begin
         io_addr_q <= instr_io_i;
         bit_q     <= instr_bit_i;
         set_q     <= instr_op_i == bio_pkg::BIO_OP_IO_SET;
      end
   end

   // ****************************************************************
   // Shift and flags
   // ****************************************************************
   bio_shift bio_shift_inst (
      .rd_i    (rd_val_i),
      .res_o   (shl_res),
      .flags_o (shl_flags)
   );

   // Only the shift touches flags; branches and bit ops leave them
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rd_we_o    <= 1'b0;
         flags_we_o <= 1'b0;
         rd_res_o   <= 8'h00;
         flags_o    <= 4'h0;
      end else if (ce_i) begin
         rd_we_o    <= acc && is_shl;
         flags_we_o <= acc && is_shl;
         if (acc && is_shl) begin
            rd_res_o <= shl_res;
            flags_o  <= shl_flags;
         end
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         en          <= `BIO_CTRL_RST;
         reg_rdata_o <= 32'h0;
      end else if (ce_i) begin
         if (reg_we_i && sel_ctrl)
            en <= reg_wdata_i[`BIO_CTRL_EN];
         reg_rdata_o <= reg_re_i ? rd_mux : 32'h0;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_ovc_jump: assert property (
      acc && is_br_ovc && !v_flag_i |=>
         pc_o == $past(pc_o) + $past(k_ext) + PCW'(1))
      else $error("overflow-clear branch target wrong");
   a_ovc_fall: assert property (
      acc && is_br_ovc && v_flag_i |=>
         pc_o == $past(pc_o) + PCW'(1) && !flush_o)
      else $error("overflow-clear branch should fall through");
   a_ien_jump: assert property (
      acc && is_br_ien && i_flag_i |=>
         (flush_o && !flags_we_o) ##1 (ready_o || !ce_i))
      else $error("interrupts-enabled branch did not take two cycles");
   a_ids_jump: assert property (
      acc && is_br_ids |=>
         flush_o == !$past(i_flag_i) && !flags_we_o)
      else $error("interrupts-disabled branch decision wrong");
   a_io_set: assert property (
      acc && instr_op_i == bio_pkg::BIO_OP_IO_SET |=>
         io_we_o == ce_i && io_addr_o == $past(instr_io_i)
         && io_wdata_o == (io_rdata_i | (8'h01 << $past(instr_bit_i))))
      else $error("set bit write wrong");
   a_io_clr: assert property (
      acc && instr_op_i == bio_pkg::BIO_OP_IO_CLR |=>
         io_we_o == ce_i && !flags_we_o
         && io_wdata_o == (io_rdata_i & ~(8'h01 << $past(instr_bit_i))))
      else $error("clear bit write wrong");
   a_shl_flags: assert property (
      acc && is_shl |=> rd_we_o && flags_we_o
         && rd_res_o == {$past(rd_val_i[6:0]), 1'b0}
         && flags_o[`BIO_FLG_C] == $past(rd_val_i[7]))
      else $error("shift result or flags wrong");
   a_br_miss: assert property (
      acc && (is_br_ovc || is_br_ien || is_br_ids) && !taken |=>
         state == bio_pkg::BIO_ST_IDLE)
      else $error("untaken branch stalled");

   c_taken:  cover property (acc && taken ##1 flush_o);
   c_io_set: cover property (acc && is_io ##1 io_we_o);
   c_shl:    cover property (acc && is_shl ##1 acc && is_shl);

endmodule
`default_nettype wire

// *** bench/bio_exec_test.sv ***
/*
 * Self-checking bench for bio_exec: a cycle model in the bench predicts
 * every output, compared on each falling edge.
 * Assumes bio_pkg and bio_exec are compiled first, default PCW of 10.
 */
`timescale 1ns/1ns
`default_nettype none
module bio_exec_test;
   localparam int PCW = 10;
   logic              clk_sys_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              ce_i = 1'b1;
   logic              instr_valid_i = 1'b0;
   bio_pkg::bio_op_t  instr_op_i = bio_pkg::BIO_OP_NONE;
   logic [6:0]        instr_k_i = 7'h00;
   logic [4:0]        instr_io_i = 5'h00;
   logic [2:0]        instr_bit_i = 3'h0;
   logic [7:0]        rd_val_i = 8'h00;
   logic              v_flag_i = 1'b0;
   logic              i_flag_i = 1'b0;
   logic [7:0]        io_rdata_i = 8'h00;
   logic [7:0]        reg_addr_i = 8'h00;
   logic [31:0]       reg_wdata_i = 32'h0;
   logic              reg_we_i = 1'b0;
   logic              reg_re_i = 1'b0;
   logic              ready_o, flush_o, io_re_o, io_we_o, rd_we_o, flags_we_o;
   logic [PCW-1:0]    pc_o;
   logic [4:0]        io_addr_o;
   logic [7:0]        io_wdata_o, rd_res_o;
   logic [3:0]        flags_o;
   logic [31:0]       reg_rdata_o;
   int                error_cnt = 0;
   int                total_checks = 0;
   // Model state
   logic [PCW-1:0]    pc_e;
   logic [1:0]        st_e;
   logic              en_e, rdwe_e, set_e;
   logic [4:0]        adr_e;
   logic [2:0]        bit_e;
   logic [7:0]        res_e;
   logic [3:0]        flg_e;
   logic [31:0]       rdata_e;

   bio_exec #(.PCW(PCW)) bio_exec_inst (.clk_sys_i, .rst_i, .ce_i,
      .instr_valid_i, .instr_op_i, .instr_k_i, .instr_io_i, .instr_bit_i,
      .rd_val_i, .v_flag_i, .i_flag_i, .ready_o, .flush_o, .pc_o,
      .io_addr_o, .io_re_o, .io_rdata_i, .io_we_o, .io_wdata_o, .rd_we_o,
      .rd_res_o, .flags_we_o, .flags_o, .reg_addr_i, .reg_wdata_i,
      .reg_we_i, .reg_re_i, .reg_rdata_o);

   always #2 clk_sys_i = ~clk_sys_i;

   // ****************************************************************
   // Reference model
   // ****************************************************************
   function automatic logic taken(input bio_pkg::bio_op_t op,
                                  input logic v, input logic i);
      return (op == bio_pkg::BIO_OP_BR_OVC && !v) ||
             (op == bio_pkg::BIO_OP_BR_IEN && i) ||
             (op == bio_pkg::BIO_OP_BR_IDS && !i);
   endfunction

   function automatic logic [3:0] shl_flags(input logic [7:0] rd);
      logic [7:0] r;
      r = {rd[6:0], 1'b0};
      return {r[7] ^ rd[7], r[7], rd[7], r == 8'h00};
   endfunction

   wire is_io = instr_op_i == bio_pkg::BIO_OP_IO_SET ||
                instr_op_i == bio_pkg::BIO_OP_IO_CLR;
   wire ready_e = ce_i & en_e & (st_e == 2'h0);
   wire acc_e = instr_valid_i & ready_e;
   wire hit_e = taken(instr_op_i, v_flag_i, i_flag_i);
   wire [7:0] mask_e = 8'h01 << bit_e;
   wire [7:0] wdat_e = set_e ? (io_rdata_i | mask_e) : (io_rdata_i & ~mask_e);
   wire [PCW-1:0] ofs_e = {{(PCW-7){instr_k_i[6]}}, instr_k_i};

   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         {pc_e, st_e, rdwe_e, res_e, flg_e, rdata_e} <= '0;
         {adr_e, bit_e, set_e} <= '0;
         en_e <= 1'b1;
      end else if (ce_i) begin
         rdwe_e <= 1'b0;
         st_e <= 2'h0;
         rdata_e <= 32'h0;
         if (reg_re_i) begin
            case (reg_addr_i)
               8'h00: rdata_e <= {31'h0, en_e};
               8'h04: rdata_e <= 32'(pc_e);
               8'h08: rdata_e <= {28'h0, flg_e};
               default: rdata_e <= 32'h0;
            endcase
         end
         if (reg_we_i && reg_addr_i == 8'h00) en_e <= reg_wdata_i[0];
         if (reg_we_i && reg_addr_i == 8'h04 && !acc_e)
            pc_e <= reg_wdata_i[PCW-1:0];
         if (acc_e) begin
            pc_e <= pc_e + 1'b1 + (hit_e ? ofs_e : '0);
            if (hit_e) st_e <= 2'h1;
            if (is_io) st_e <= 2'h2;
            adr_e <= instr_io_i;
            bit_e <= instr_bit_i;
            set_e <= instr_op_i == bio_pkg::BIO_OP_IO_SET;
            if (instr_op_i == bio_pkg::BIO_OP_SHL) begin
               rdwe_e <= 1'b1;
               res_e <= {rd_val_i[6:0], 1'b0};
               flg_e <= shl_flags(rd_val_i);
            end
         end
      end
   end

   // ****************************************************************
   // Checking
   // ****************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   always @(negedge clk_sys_i) begin
      if (!rst_i) begin
         check(ready_o, ready_e, "ready");
         check(flush_o, st_e == 2'h1, "flush");
         check(pc_o, pc_e, "pc");
         check(io_re_o, acc_e & is_io, "io read");
         if (acc_e & is_io) check(io_addr_o, instr_io_i, "io addr");
         check(io_we_o, ce_i && st_e == 2'h2, "io write");
         if (st_e == 2'h2)
            check({io_addr_o, io_wdata_o}, {adr_e, wdat_e}, "rmw");
         check({rd_we_o, flags_we_o}, {2{rdwe_e}}, "shift strobes");
         check({rd_res_o, flags_o}, {res_e, flg_e}, "shift result");
         check(reg_rdata_o, rdata_e, "reg read");
      end
   end

   task automatic stop_test();
      if (error_cnt == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ****************************************************************
   // Stimulus
   // ****************************************************************
   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_we_i <= we;
      reg_re_i <= !we;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_we_i <= 1'b0;
      reg_re_i <= 1'b0;
   endtask

   task automatic rnd(input int n);
      int r;
      repeat (n) begin
         @(posedge clk_sys_i);
         r = $urandom % 8;
         instr_valid_i <= ($urandom % 4) != 0;
         instr_op_i <= bio_pkg::bio_op_t'(3'($urandom % 7));
         instr_k_i <= 7'($urandom);
         instr_io_i <= 5'($urandom);
         instr_bit_i <= 3'($urandom);
         rd_val_i <= 8'($urandom);
         v_flag_i <= 1'($urandom);
         i_flag_i <= 1'($urandom);
         io_rdata_i <= 8'($urandom);
         reg_we_i <= r == 0;
         reg_re_i <= r == 1;
         reg_addr_i <= 8'(($urandom % 5) * 4);
         reg_wdata_i <= $urandom | 32'h1;
      end
      @(posedge clk_sys_i);
      {instr_valid_i, reg_we_i, reg_re_i} <= 3'h0;
   endtask

   initial begin
      #(4 * 6000);
      error_cnt++;
      stop_test();
   end

   initial begin
      void'($urandom(42702));
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 5; a++) bus(1'b0, 8'(a * 4), 32'h0);
      bus(1'b1, 8'h08, 32'hffffffff);
      bus(1'b1, 8'h40, 32'hffffffff);
      bus(1'b0, 8'h08, 32'h0);
      // Both outcomes of every branch, both ends of offset, bit and shift
      for (int o = 0; o < 7; o++) begin
         for (int j = 0; j < 2; j++) begin
            @(posedge clk_sys_i);
            instr_valid_i <= 1'b1;
            instr_op_i <= bio_pkg::bio_op_t'(3'(o));
            {v_flag_i, i_flag_i} <= {2{j[0]}};
            instr_k_i <= j[0] ? 7'h40 : 7'h3f;
            instr_bit_i <= j[0] ? 3'h7 : 3'h0;
            rd_val_i <= j[0] ? 8'h80 : 8'h40;
            io_rdata_i <= 8'($urandom);
            instr_io_i <= 5'(o * 4 + j);
            @(posedge clk_sys_i);
            instr_valid_i <= 1'b0;
            @(posedge clk_sys_i);
         end
      end
      // Offered while disabled: must wait for enable, then for clock enable
      bus(1'b1, 8'h00, 32'h0);
      instr_valid_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      bus(1'b1, 8'h00, 32'h1);
      ce_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      ce_i <= 1'b1;
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      bus(1'b1, 8'h04, 32'h3fe);
      // Clock enable dropped in the write-back cycle of a bit clear
      instr_op_i <= bio_pkg::BIO_OP_IO_CLR;
      instr_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      ce_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      ce_i <= 1'b1;
      rnd(1500);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rnd(300);
      stop_test();
   end
endmodule
`default_nettype wire
